// ---- logic/acc_add_cfg.svh ----
// Offsets, field positions, reset values and widths for the accumulator add unit
`ifndef ACC_ADD_CFG_SVH
`define ACC_ADD_CFG_SVH

// ==========================================================
// Register offsets
`define ACC_REG_ACC 8'h00
`define ACC_REG_BUF 8'h04
`define ACC_REG_SHIFT 8'h08
`define ACC_REG_STATUS 8'h0c
`define ACC_REG_PC 8'h10

// ==========================================================
// Status register fields
`define ACC_ST_CARRY 0
`define ACC_ST_EXCESS 1
`define ACC_ST_SIGNEXT 2
`define ACC_ST_CLAMP 3
`define ACC_ST_AUX_LO 4
`define ACC_ST_AUX_HI 6
`define ACC_ST_BUSY 7

// ==========================================================
// Reset values and limits
`define ACC_RST_WORD 32'h0000_0000
`define ACC_RST_PC 16'h0000
`define ACC_MAX_POS 32'h7fff_ffff
`define ACC_MAX_NEG 32'h8000_0000
`define ACC_PC_STEP 16'h0001
`define ACC_SHIFT_BITS 4
`define ACC_PAGE_BITS 9
`define ACC_OFFSET_BITS 7
`define ACC_AUX_BITS 3
`define ACC_REP_BITS 8
`define ACC_WAIT_BITS 4

`endif

// ---- logic/acc_add_pkg.sv ----
// Types shared by the accumulator add unit
package acc_add_pkg;

	// ==========================================================
	// Add variants
	typedef enum logic [1:0] {
		OP_ADD_BUF = 2'h0,
		OP_ADD_CARRY = 2'h1,
		OP_ADD_UNSIGNED = 2'h2,
		OP_ADD_VAR_SHIFT = 2'h3
	} add_op_e;

	// ==========================================================
	// Sequencer states, Gray coded along idle, wait, stall, exec
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_STALL = 2'h3,
		ST_EXEC = 2'h2
	} seq_state_e;

	typedef struct packed {
		seq_state_e state;
		add_op_e op;
		logic [31:0] acc;
		logic [31:0] accumulator_buffer;
		logic [15:0] shift_count;
		logic carry;
		logic excess;
		logic sign_ext;
		logic clamp;
		logic [2:0] aux_sel;
		logic [15:0] pc;
		logic [7:0] rep_left;
		logic [3:0] wait_left;
		logic stall_pend;
		logic [15:0] addr;
		logic [31:0] rdata;
	} unit_state_s;

endpackage : acc_add_pkg

// ---- logic/operand_shaper.sv ----
// Builds the 32-bit addend and carry-in for each add variant
`include "acc_add_cfg.svh"

module operand_shaper (
	input wire acc_add_pkg::add_op_e i_op,
	input wire logic [15:0] i_mem_data,
	input wire logic [31:0] i_accumulator_buffer,
	input wire logic i_sign_ext,
	input wire logic [3:0] i_shift,
	input wire logic i_carry,
	output logic [31:0] o_addend,
	output logic o_carry_in
);

	logic [31:0] ext_word;

	always_comb begin
		ext_word = i_sign_ext ? {{16{i_mem_data[15]}}, i_mem_data} : {16'h0000, i_mem_data};
		o_addend = `ACC_RST_WORD;
		o_carry_in = 1'b0;
		unique case (i_op)
			acc_add_pkg::OP_ADD_BUF: begin
				o_addend = i_accumulator_buffer;
			end
			acc_add_pkg::OP_ADD_CARRY: begin
				o_addend = {16'h0000, i_mem_data};
				o_carry_in = i_carry;
			end
			acc_add_pkg::OP_ADD_UNSIGNED: begin
				// Same as a plain add with no sign extension and no shift
				o_addend = {16'h0000, i_mem_data};
			end
			acc_add_pkg::OP_ADD_VAR_SHIFT: begin
				o_addend = ext_word << i_shift;
			end
		endcase
	end

endmodule : operand_shaper

// ---- logic/acc_add_unit.sv ----
// Accumulator datapath and sequencer for the four add variants
// Summary of operation
// - Carry add: accumulator plus zero-extended memory word plus current carry.
// - Carry add updates carry like any ordinary accumulator addition.
// - Carry and unsigned add_unsigned_operand honour clamping, set carry and excess, ignore sign mode.
// - Unsigned add zero-fills the memory word regardless of sign mode.
// - Unsigned add treats the accumulator as signed 32-bit.
// - Unsigned add equals plain add with sign mode clear and shift zero.
// - Variable-shift add shifts the word left by shift register bits 3..0.
// - Variable-shift add sign-extends the word when sign mode is one.
// - Variable-shift add zero-fills upper bits when sign mode is clear.
// - Variable-shift add depends on sign and clamp modes, updates carry and excess.
// - Direct offset spans 0..127 in the page; next aux pointer spans 0..7.
// - Operand and code in the same single-access block cost one extra cycle.
// - Repeated on-chip add_unsigned_operand take n cycles plus program wait cycles.
// - Buffer add sums the accumulator buffer, clamps, updates carry and excess.
`include "acc_add_cfg.svh"

module acc_add_unit #(
	parameter int REP_BITS = `ACC_REP_BITS,
	parameter int WAIT_BITS = `ACC_WAIT_BITS
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_op_valid,
	input wire acc_add_pkg::add_op_e i_op,
	input wire logic i_indirect,
	input wire logic [6:0] i_dma_offset,
	input wire logic [8:0] i_data_page,
	input wire logic [15:0] i_ind_addr,
	input wire logic i_next_aux_valid,
	input wire logic [2:0] i_next_aux,
	input wire logic i_same_single_access_ram,
	input wire logic [REP_BITS-1:0] i_repeat_count,
	input wire logic [WAIT_BITS-1:0] i_prog_wait,
	input wire logic [15:0] i_mem_data,
	output logic o_ready,
	output logic o_busy,
	output logic o_done,
	output logic o_mem_rd,
	output logic [15:0] o_mem_addr,
	output logic [31:0] o_acc,
	output logic o_carry,
	output logic o_excess,
	output logic [2:0] o_aux_sel,
	output logic [15:0] o_pc,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata
);

	// ==========================================================
	// State and datapath wires
	acc_add_pkg::unit_state_s cur_r;
	acc_add_pkg::unit_state_s cur_nxt;
	logic [31:0] addend;
	logic carry_in;
	logic [32:0] wide_sum;
	logic [31:0] raw_sum;
	logic overflow;
	logic start;
	logic exec;
	logic last_exec;

	operand_shaper u_shaper (
		.i_op(cur_r.op),
		.i_mem_data(i_mem_data),
		.i_accumulator_buffer(cur_r.accumulator_buffer),
		.i_sign_ext(cur_r.sign_ext),
		.i_shift(cur_r.shift_count[`ACC_SHIFT_BITS-1:0]),
		.i_carry(cur_r.carry),
		.o_addend(addend),
		.o_carry_in(carry_in)
	);

	// ==========================================================
	// Adder with carry-out and signed overflow detection
	always_comb begin
		wide_sum = {1'b0, cur_r.acc} + {1'b0, addend} + {32'h0000_0000, carry_in};
		raw_sum = wide_sum[31:0];
		// Accumulator is signed; addend sign bit decides the overflow direction
		overflow = (cur_r.acc[31] == addend[31]) && (raw_sum[31] != cur_r.acc[31]);
	end

	assign start = i_op_valid && (cur_r.state == acc_add_pkg::ST_IDLE);
	assign exec = cur_r.state == acc_add_pkg::ST_EXEC;
	assign last_exec = exec && (cur_r.rep_left <= 8'h01);

	// ==========================================================
	// Next-state logic
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.rdata = `ACC_RST_WORD;

		// Register bus writes
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				`ACC_REG_ACC: cur_nxt.acc = i_reg_wdata;
				`ACC_REG_BUF: cur_nxt.accumulator_buffer = i_reg_wdata;
				`ACC_REG_SHIFT: cur_nxt.shift_count = i_reg_wdata[15:0];
				`ACC_REG_STATUS: begin
					cur_nxt.carry = i_reg_wdata[`ACC_ST_CARRY];
					// Excess flag clears on writing one; a new overflow below wins
					if (i_reg_wdata[`ACC_ST_EXCESS]) begin
						cur_nxt.excess = 1'b0;
					end
					cur_nxt.sign_ext = i_reg_wdata[`ACC_ST_SIGNEXT];
					cur_nxt.clamp = i_reg_wdata[`ACC_ST_CLAMP];
					cur_nxt.aux_sel = i_reg_wdata[`ACC_ST_AUX_HI:`ACC_ST_AUX_LO];
				end
				`ACC_REG_PC: cur_nxt.pc = i_reg_wdata[15:0];
				default: begin
				end
			endcase
		end

		// Register bus reads, answered one cycle later
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				`ACC_REG_ACC: cur_nxt.rdata = cur_r.acc;
				`ACC_REG_BUF: cur_nxt.rdata = cur_r.accumulator_buffer;
				`ACC_REG_SHIFT: cur_nxt.rdata = {16'h0000, cur_r.shift_count};
				`ACC_REG_STATUS: begin
					cur_nxt.rdata[`ACC_ST_CARRY] = cur_r.carry;
					cur_nxt.rdata[`ACC_ST_EXCESS] = cur_r.excess;
					cur_nxt.rdata[`ACC_ST_SIGNEXT] = cur_r.sign_ext;
					cur_nxt.rdata[`ACC_ST_CLAMP] = cur_r.clamp;
					cur_nxt.rdata[`ACC_ST_AUX_HI:`ACC_ST_AUX_LO] = cur_r.aux_sel;
					cur_nxt.rdata[`ACC_ST_BUSY] = cur_r.state != acc_add_pkg::ST_IDLE;
				end
				`ACC_REG_PC: cur_nxt.rdata = {16'h0000, cur_r.pc};
				default: cur_nxt.rdata = `ACC_RST_WORD;
			endcase
		end

		// Sequencer
		unique case (cur_r.state)
			acc_add_pkg::ST_IDLE: begin
				if (start) begin
					cur_nxt.op = i_op;
					// Page field selects one of 512 pages of 128 words each
					cur_nxt.addr = i_indirect ? i_ind_addr : {i_data_page, i_dma_offset};
					if (i_indirect && i_next_aux_valid) begin
						cur_nxt.aux_sel = i_next_aux;
					end
					cur_nxt.rep_left = (i_repeat_count == '0) ? 8'h01 : 8'(i_repeat_count);
					cur_nxt.wait_left = 4'(i_prog_wait);
					cur_nxt.stall_pend = i_same_single_access_ram;
					if (i_prog_wait != '0) begin
						cur_nxt.state = acc_add_pkg::ST_WAIT;
					end else if (i_same_single_access_ram) begin
						cur_nxt.state = acc_add_pkg::ST_STALL;
					end else begin
						cur_nxt.state = acc_add_pkg::ST_EXEC;
					end
				end
			end
			acc_add_pkg::ST_WAIT: begin
				cur_nxt.wait_left = cur_r.wait_left - 4'h1;
				if (cur_r.wait_left == 4'h1) begin
					cur_nxt.state = cur_r.stall_pend ? acc_add_pkg::ST_STALL : acc_add_pkg::ST_EXEC;
				end
			end
			acc_add_pkg::ST_STALL: begin
				// One extra cycle for the whole run, not one per repetition
				cur_nxt.stall_pend = 1'b0;
				cur_nxt.state = acc_add_pkg::ST_EXEC;
			end
			acc_add_pkg::ST_EXEC: begin
				// One repetition per cycle
				cur_nxt.rep_left = cur_r.rep_left - 8'h01;
				cur_nxt.carry = wide_sum[32];
				if (overflow) begin
					cur_nxt.excess = 1'b1;
				end
				if (overflow && cur_r.clamp) begin
					cur_nxt.acc = cur_r.acc[31] ? `ACC_MAX_NEG : `ACC_MAX_POS;
				end else begin
					cur_nxt.acc = raw_sum;
				end
				if (last_exec) begin
					cur_nxt.pc = cur_r.pc + `ACC_PC_STEP;
					cur_nxt.state = acc_add_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			cur_r <= '{
				state: acc_add_pkg::ST_IDLE,
				op: acc_add_pkg::OP_ADD_BUF,
				acc: `ACC_RST_WORD,
				accumulator_buffer: `ACC_RST_WORD,
				shift_count: 16'h0000,
				carry: 1'b0,
				excess: 1'b0,
				sign_ext: 1'b0,
				clamp: 1'b0,
				aux_sel: 3'h0,
				pc: `ACC_RST_PC,
				rep_left: 8'h00,
				wait_left: 4'h0,
				stall_pend: 1'b0,
				addr: 16'h0000,
				rdata: `ACC_RST_WORD
			};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_ready = cur_r.state == acc_add_pkg::ST_IDLE;
	assign o_busy = cur_r.state != acc_add_pkg::ST_IDLE;
	assign o_done = last_exec;
	assign o_mem_rd = exec && (cur_r.op != acc_add_pkg::OP_ADD_BUF);
	assign o_mem_addr = cur_r.addr;
	assign o_acc = cur_r.acc;
	assign o_carry = cur_r.carry;
	assign o_excess = cur_r.excess;
	assign o_aux_sel = cur_r.aux_sel;
	assign o_pc = cur_r.pc;
	assign o_reg_rdata = cur_r.rdata;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	logic no_clamp_step;
	assign no_clamp_step = exec && !(overflow && cur_r.clamp) && !i_reg_wr;

	sequence s_single_start(logic single_access_ram);
		start && i_repeat_count == 8'h01 && i_prog_wait == '0 && i_same_single_access_ram == single_access_ram;
	endsequence

	sequence s_run_of_three;
		start && i_repeat_count == 8'h03 && i_prog_wait == '0 && !i_same_single_access_ram;
	endsequence

	a_carry_add_sum: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_CARRY
		|=> o_acc == $past(cur_r.acc) + {16'h0000, $past(i_mem_data)} + {31'h0, $past(cur_r.carry)})
		else $error("carry add result wrong");

	a_carry_out_set: assert property (
		exec && !i_reg_wr && cur_r.op == acc_add_pkg::OP_ADD_CARRY && cur_r.acc == 32'hffff_ffff
		&& i_mem_data != 16'h0000 |=> o_carry)
		else $error("carry not set on carry out");

	a_unsigned_sum: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_UNSIGNED
		|=> o_acc == $past(cur_r.acc) + {16'h0000, $past(i_mem_data)})
		else $error("unsigned add not zero filled");

	a_shift_signed: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_VAR_SHIFT && cur_r.sign_ext
		|=> o_acc == $past(cur_r.acc)
		+ ({{16{$past(i_mem_data[15])}}, $past(i_mem_data)} << $past(cur_r.shift_count[3:0])))
		else $error("signed shift add wrong");

	a_shift_zero_fill: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_VAR_SHIFT && !cur_r.sign_ext
		|=> o_acc == $past(cur_r.acc) + ({16'h0000, $past(i_mem_data)} << $past(cur_r.shift_count[3:0])))
		else $error("zero fill shift add wrong");

	a_clamp_saturate: assert property (
		exec && !i_reg_wr && cur_r.clamp && overflow
		|=> (o_acc == `ACC_MAX_POS || o_acc == `ACC_MAX_NEG) && o_excess)
		else $error("overflow not clamped");

	a_pc_step: assert property (
		last_exec && !i_reg_wr |=> o_pc == $past(cur_r.pc) + `ACC_PC_STEP && o_ready)
		else $error("program counter not stepped by one");

	a_single_access_ram_stall: assert property (
		s_single_start(1'b1) |=> o_busy [*2] ##1 o_ready)
		else $error("same block add not two cycles");

	a_repeat_length: assert property (
		s_run_of_three |=> (o_busy && !o_done) [*2] ##1 (o_busy && o_done) ##1 !o_busy)
		else $error("repeat run length wrong");

	a_direct_address: assert property (
		start && !i_indirect |=> o_mem_addr[6:0] == $past(i_dma_offset))
		else $error("direct offset lost");

	a_single_one_cycle: assert property (
		s_single_start(1'b0) |=> o_done ##1 o_ready)
		else $error("single add not one cycle");

	a_buffer_sum: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_BUF
		|=> o_acc == $past(cur_r.acc) + $past(cur_r.accumulator_buffer))
		else $error("buffer add result wrong");

	a_carry_no_out: assert property (
		exec && !i_reg_wr && cur_r.op == acc_add_pkg::OP_ADD_CARRY && cur_r.acc[31:16] == 16'h0000
		|=> !o_carry)
		else $error("carry set without carry out");

	a_excess_on_overflow: assert property (
		exec && !i_reg_wr && !cur_r.clamp && cur_r.acc[31] == addend[31]
		|=> o_acc[31] == $past(cur_r.acc[31]) || o_excess)
		else $error("overflow did not set excess");

	a_aux_load: assert property (
		start && i_indirect && i_next_aux_valid
		|=> o_aux_sel == $past(i_next_aux))
		else $error("aux pointer select not loaded");

	a_shift_low_bits: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_VAR_SHIFT && !cur_r.sign_ext
		&& cur_r.shift_count[3:0] == 4'h0
		|=> o_acc == $past(cur_r.acc) + {16'h0000, $past(i_mem_data)})
		else $error("shift count upper bits used");

	a_wait_first: assert property (
		start && i_prog_wait == 4'h2
		|=> (o_busy && !o_mem_rd && !o_done) [*2])
		else $error("program wait cycles missing");

	a_stall_once_run: assert property (
		start && i_same_single_access_ram && i_prog_wait == 4'h2 && i_repeat_count == 8'h03
		|=> (o_busy && !o_done) [*5] ##1 o_done ##1 o_ready)
		else $error("same block run not n plus one");

	a_unsigned_sign_mode: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_UNSIGNED && cur_r.sign_ext && i_mem_data[15]
		|=> o_acc == $past(cur_r.acc) + {16'h0000, $past(i_mem_data)})
		else $error("unsigned add used sign mode");

	a_unsigned_neg_acc: assert property (
		no_clamp_step && cur_r.op == acc_add_pkg::OP_ADD_UNSIGNED && cur_r.acc[31]
		|=> (o_acc[31] || o_carry) && o_excess == $past(cur_r.excess))
		else $error("negative accumulator not treated as signed");

endmodule : acc_add_unit

// ---- test/accumulator_add_variants_tb.sv ----
// Self-checking bench for the accumulator add unit
`include "acc_add_cfg.svh"

module accumulator_add_variants_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Stimulus and model state
	logic clk = 1'b0, rstn = 1'b0, i_op_valid = 1'b0, i_indirect = 1'b0, i_next_aux_valid = 1'b0;
	logic i_same_single_access_ram = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	acc_add_pkg::add_op_e i_op = acc_add_pkg::OP_ADD_BUF;
	logic [6:0] i_dma_offset = 7'h00;
	logic [8:0] i_data_page = 9'h000;
	logic [15:0] i_ind_addr = 16'h0000, i_mem_data = 16'h0000;
	logic [2:0] i_next_aux = 3'h0;
	logic [7:0] i_repeat_count = 8'h00, i_reg_addr = 8'h00;
	logic [3:0] i_prog_wait = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0000_0000, rd;
	logic o_ready, o_busy, o_done, o_mem_rd, o_carry, o_excess;
	logic [15:0] o_mem_addr, o_pc;
	logic [31:0] o_acc, o_reg_rdata;
	logic [2:0] o_aux_sel;
	logic [31:0] m_acc, m_accumulator_buffer;
	logic [15:0] shift;
	logic m_c, m_ex, sx, clamp;
	int num_errors = 0, checked = 0;

	acc_add_unit i_acc_add_unit (.i_clk_sys(clk), .i_resetn(rstn), .i_op_valid(i_op_valid), .i_op(i_op),
		.i_indirect(i_indirect), .i_dma_offset(i_dma_offset), .i_data_page(i_data_page),
		.i_ind_addr(i_ind_addr), .i_next_aux_valid(i_next_aux_valid), .i_next_aux(i_next_aux),
		.i_same_single_access_ram(i_same_single_access_ram), .i_repeat_count(i_repeat_count), .i_prog_wait(i_prog_wait),
		.i_mem_data(i_mem_data), .o_ready(o_ready), .o_busy(o_busy), .o_done(o_done), .o_mem_rd(o_mem_rd),
		.o_mem_addr(o_mem_addr), .o_acc(o_acc), .o_carry(o_carry), .o_excess(o_excess), .o_aux_sel(o_aux_sel),
		.o_pc(o_pc), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge clk);
		i_reg_rd <= 1'b0;
		@(negedge clk);
		rd = o_reg_rdata;
	endtask : reg_rd

	// One execute step: returns overflow, carry and new accumulator
	function automatic logic [33:0] ref_step(acc_add_pkg::add_op_e op, logic [31:0] a, logic [15:0] m, logic c);
		logic [31:0] ad;
		logic [32:0] s;
		logic ov;
		ad = {16'h0000, m};
		if (op == acc_add_pkg::OP_ADD_BUF) ad = m_accumulator_buffer;
		if (op == acc_add_pkg::OP_ADD_VAR_SHIFT) ad = (sx ? {{16{m[15]}}, m} : {16'h0000, m}) << shift[3:0];
		s = {1'b0, a} + {1'b0, ad} + {32'h0, (op == acc_add_pkg::OP_ADD_CARRY) & c};
		ov = (a[31] == ad[31]) && (s[31] != a[31]);
		if (ov && clamp) s[31:0] = a[31] ? `ACC_MAX_NEG : `ACC_MAX_POS;
		return {ov, s[32], s[31:0]};
	endfunction : ref_step

	task automatic run(input acc_add_pkg::add_op_e op, input logic [31:0] a, accumulator_buffer, input logic [15:0] m0, sh,
		input logic c, x, cl, input int n, p, s);
		logic [15:0] w[9];
		logic [15:0] ea;
		logic [2:0] aux, eaux;
		logic [33:0] r;
		logic dn;
		int cyc, k, ne;
		for (int j = 0; j < 9; j++) w[j] = 16'($urandom);
		w[0] = m0;
		ne = (n == 0) ? 1 : n;
		aux = 3'($urandom);
		sx = x;
		clamp = cl;
		m_accumulator_buffer = accumulator_buffer;
		shift = sh;
		reg_wr(`ACC_REG_ACC, a);
		reg_wr(`ACC_REG_BUF, accumulator_buffer);
		reg_wr(`ACC_REG_SHIFT, {16'h0000, sh});
		reg_wr(`ACC_REG_PC, 32'h0000_0100);
		reg_wr(`ACC_REG_STATUS, {24'h000000, 1'b0, aux, cl, x, 1'b1, c});
		m_acc = a;
		m_c = c;
		m_ex = 1'b0;
		@(posedge clk);
		i_op_valid <= 1'b1;
		i_op <= op;
		i_indirect <= 1'($urandom);
		i_dma_offset <= 7'($urandom);
		i_data_page <= 9'($urandom);
		i_ind_addr <= 16'($urandom);
		i_next_aux_valid <= 1'($urandom);
		i_next_aux <= 3'($urandom);
		i_repeat_count <= 8'(n);
		i_prog_wait <= 4'(p);
		i_same_single_access_ram <= 1'(s);
		i_mem_data <= w[0];
		@(posedge clk);
		i_op_valid <= 1'b0;
		ea = i_indirect ? i_ind_addr : {i_data_page, i_dma_offset};
		eaux = (i_indirect && i_next_aux_valid) ? i_next_aux : aux;
		cyc = 0;
		k = 0;
		do begin
			@(negedge clk);
			cyc++;
			check("busy", o_busy, 1'b1);
			check("done", o_done, cyc == p + s + ne);
			check("mem_rd", o_mem_rd, (cyc > p + s) && (op != acc_add_pkg::OP_ADD_BUF));
			if (cyc > p + s) begin
				if (op != acc_add_pkg::OP_ADD_BUF) check("mem_addr", o_mem_addr, ea);
				r = ref_step(op, m_acc, w[k], m_c);
				m_acc = r[31:0];
				m_c = r[32];
				m_ex = m_ex | r[33];
				k++;
			end
			dn = o_done;
			@(posedge clk);
			i_mem_data <= w[k];
		end while (!dn && cyc < 40);
		check("done_cycle", cyc, p + s + ne);
		#1;
		check("acc", o_acc, m_acc);
		check("carry", o_carry, m_c);
		check("excess", o_excess, m_ex);
		check("aux", o_aux_sel, eaux);
		check("ready", o_ready, 1'b1);
		check("pc", o_pc, 16'h0101);
	endtask : run

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(40284));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		check("ready_rst", o_ready, 1'b1);
		reg_rd(`ACC_REG_ACC);
		check("acc_rst", rd, `ACC_RST_WORD);
		reg_rd(`ACC_REG_STATUS);
		check("status_rst", rd, 32'h0000_0000);
		reg_rd(`ACC_REG_PC);
		check("pc_rst", rd, 32'h0000_0000);
		reg_wr(`ACC_REG_ACC, 32'h1234_5678);
		reg_wr(8'h14, 32'hffff_ffff);
		reg_rd(8'h14);
		check("unmapped", rd, 32'h0000_0000);
		reg_rd(`ACC_REG_ACC);
		check("acc_rw", rd, 32'h1234_5678);
		@(negedge clk);
		check("rdata_idle", o_reg_rdata, 32'h0000_0000);
		$display("test registers done");
		run(acc_add_pkg::OP_ADD_CARRY, 32'h0000_0013, 0, 16'h0004, 0, 1, 1, 0, 1, 0, 0);
		run(acc_add_pkg::OP_ADD_CARRY, 32'hffff_ffff, 0, 16'hffff, 0, 1, 1, 0, 2, 0, 0);
		run(acc_add_pkg::OP_ADD_CARRY, 32'hffff_fff0, 0, 16'h0020, 0, 0, 1, 0, 3, 0, 0);
		run(acc_add_pkg::OP_ADD_UNSIGNED, 32'h07ff_0000, 0, 16'hffff, 5, 0, 1, 0, 1, 0, 0);
		run(acc_add_pkg::OP_ADD_UNSIGNED, 32'h7fff_ff00, 0, 16'hf006, 0, 0, 1, 1, 1, 1, 1);
		run(acc_add_pkg::OP_ADD_BUF, 32'h7fff_ffff, 32'h0000_0001, 0, 0, 0, 0, 1, 1, 0, 0);
		run(acc_add_pkg::OP_ADD_BUF, 32'h8000_0000, 32'hffff_ffff, 0, 0, 0, 0, 1, 3, 2, 1);
		run(acc_add_pkg::OP_ADD_VAR_SHIFT, 32'h0000_f715, 0, 16'h0009, 16'hff94, 0, 0, 0, 1, 0, 0);
		run(acc_add_pkg::OP_ADD_VAR_SHIFT, 32'h0000_0000, 0, 16'h8000, 16'h000f, 0, 1, 1, 4, 3, 1);
		run(acc_add_pkg::OP_ADD_VAR_SHIFT, 32'h0000_0000, 0, 16'h8000, 16'h0010, 0, 0, 1, 1, 0, 1);
		$display("test directed done");
		repeat (30) begin
			run(acc_add_pkg::add_op_e'($urandom_range(0, 3)), $urandom, $urandom, 16'($urandom), 16'($urandom),
				1'($urandom), 1'($urandom), 1'($urandom), $urandom_range(0, 4), $urandom_range(0, 3),
				$urandom_range(0, 1));
		end
		$display("test random done");
		end_of_test();
	end

	// ==========================================================
	// Watchdog
	initial begin
		#(40000 * 5);
		num_errors++;
		end_of_test();
	end

endmodule : accumulator_add_variants_tb
